// *** src/tbmd_master.sv ***
// master end: drives multiplexed backplane data, set up over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tbmd_master
  import tbmd_pkg::*;
#(
  parameter int SfFrames = SF_FRAMES_DEF
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // backplane link
  tbmd_link_if.master      link
);

  typedef enum logic [1:0] {
    CFG_IDLE  = 2'b00,
    CFG_IFACE = 2'b01,
    CFG_FRAME = 2'b10
  } tbmd_cfg_t;

  // ***********************************
  // register file and axi slave
  // ***********************************
  logic [4:0]  ctrl_r;
  logic [31:0] pattern_r;
  logic [7:0]  halfDiv_r;
  logic [15:0] framesSent_r;
  logic        active_r;
  logic        cfgPend_r;
  tbmd_cfg_t   cfg_r;
  logic [3:0]  awAddr_r;
  logic [31:0] wData_r;
  logic        awHave_r;
  logic        wHave_r;
  logic        doWrite;

  // both halves held until the response is taken, so one write at a time
  assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
      awAddr_r      <= 4'h0;
      wData_r       <= 32'h0;
      awHave_r      <= 1'b0;
      wHave_r       <= 1'b0;
      ctrl_r        <= 5'h00;
      pattern_r     <= 32'h0;
      halfDiv_r     <= HS_HALF_DIV;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_r      <= s_axi_awaddr;
        awHave_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!awHave_r)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r      <= s_axi_wdata;
        wHave_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!wHave_r)
        s_axi_wready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        awHave_r      <= 1'b0;
        wHave_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      else if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= AXI_OKAY;
        // whole-word registers; byte strobes are not honoured
        case (awAddr_r)
          CTRL_OFS:    ctrl_r    <= wData_r[4:0];
          PATTERN_OFS: pattern_r <= wData_r;
          DIV_OFS:     halfDiv_r <= (wData_r[7:0] == 8'h00) ? 8'h01 : wData_r[7:0];
          STATUS_OFS:  ;
          default:     s_axi_bresp <= AXI_SLVERR;
        endcase
      end
    end
  end

  // ***********************************
  // read channel
  // ***********************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= AXI_OKAY;
      case (s_axi_araddr)
        CTRL_OFS:    s_axi_rdata <= {27'h0, ctrl_r};
        PATTERN_OFS: s_axi_rdata <= pattern_r;
        STATUS_OFS:  s_axi_rdata <= {framesSent_r, 13'h0, cfg_r != CFG_IDLE,
                                     cfgPend_r, active_r};
        DIV_OFS:     s_axi_rdata <= {24'h0, halfDiv_r};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ***********************************
  // link clock dividers
  // ***********************************
  logic [7:0] hsCnt_r;
  logic [7:0] baseCnt_r;
  logic       fallEv;

  // link pins change with the falling edge, half a bit ahead of sampling
  assign fallEv = (hsCnt_r >= halfDiv_r - 8'h01) && link.hsClk;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      hsCnt_r      <= 8'h00;
      baseCnt_r    <= 8'h00;
      link.hsClk   <= 1'b0;
      link.baseClk <= 1'b0;
    end
    else
    begin
      hsCnt_r   <= (hsCnt_r >= halfDiv_r - 8'h01) ? 8'h00 : hsCnt_r + 8'h01;
      baseCnt_r <= (baseCnt_r >= BASE_HALF_DIV - 8'h01) ? 8'h00 : baseCnt_r + 8'h01;
      if (hsCnt_r >= halfDiv_r - 8'h01)
        link.hsClk <= !link.hsClk;
      if (baseCnt_r >= BASE_HALF_DIV - 8'h01)
        link.baseClk <= !link.baseClk;
    end
  end

  // ***********************************
  // device configuration writes
  // ***********************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_r          <= CFG_IDLE;
      cfgPend_r      <= 1'b0;
      link.regWrite  <= 1'b0;
      link.regAddr   <= '0;
      link.regWrData <= '0;
    end
    else
    begin
      if (doWrite && awAddr_r == CTRL_OFS)
        cfgPend_r <= 1'b1;
      else if (fallEv && cfg_r == CFG_IDLE)
        cfgPend_r <= 1'b0;
      if (fallEv)
      begin
        case (cfg_r)
          CFG_IDLE:
          begin
            link.regWrite <= cfgPend_r;
            link.regAddr  <= IFACE_CTRL_OFS;
            link.regWrData <= {ctrl_r[CTRL_MUX_BIT], 5'h00,
                               ctrl_r[CTRL_SPD_LSB+1:CTRL_SPD_LSB]};
            cfg_r <= cfgPend_r ? CFG_IFACE : CFG_IDLE;
          end
          CFG_IFACE:
          begin
            link.regAddr   <= FRAME_CFG_OFS;
            link.regWrData <= {2'b00, ctrl_r[CTRL_SF_BIT], 5'h00};
            cfg_r          <= CFG_FRAME;
          end
          default:
          begin
            link.regWrite <= 1'b0;
            cfg_r         <= CFG_IDLE;
          end
        endcase
      end
    end
  end

  // ***********************************
  // frame generator
  // ***********************************
  tbmd_speed_t speed;
  logic [11:0] len;
  logic [11:0] bitNxt;
  logic [11:0] txBit_r;
  logic [7:0]  txFrame_r;
  logic [7:0]  frameNxt;
  logic        headOk;
  logic        tailOk;
  logic        pulseNxt;

  always_comb
  begin
    speed  = tbmd_speed_t'(ctrl_r[CTRL_SPD_LSB+1:CTRL_SPD_LSB]);
    len    = frameLen(speed);
    bitNxt = (!active_r || txBit_r >= len - 12'h001) ? 12'h000 : txBit_r + 12'h001;
    if (!active_r)
      frameNxt = 8'h00;
    else if (bitNxt != 12'h000)
      frameNxt = txFrame_r;
    else
      frameNxt = (txFrame_r >= 8'(SfFrames - 1)) ? 8'h00 : txFrame_r + 8'h01;
    headOk = !ctrl_r[CTRL_SF_BIT] || frameNxt == 8'h00;
    tailOk = !ctrl_r[CTRL_SF_BIT] || frameNxt == 8'(SfFrames - 1);
    case (speed)
      SPEED_BIT_12M: pulseNxt = headOk && bitNxt < FP_LEN_BIT;
      SPEED_HMVIP:   pulseNxt = (headOk && bitNxt < OFF_HMVIP)
                                || (tailOk && bitNxt >= len - OFF_HMVIP);
      SPEED_H100:    pulseNxt = (headOk && bitNxt < OFF_H100)
                                || (tailOk && bitNxt >= len - OFF_H100);
      default:       pulseNxt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      active_r        <= 1'b0;
      txBit_r         <= 12'h000;
      txFrame_r       <= 8'h00;
      framesSent_r    <= 16'h0000;
      link.framePulse <= 1'b0;
      link.serialData <= 1'b0;
    end
    else if (fallEv)
    begin
      active_r        <= ctrl_r[CTRL_RUN_BIT];
      txBit_r         <= bitNxt;
      txFrame_r       <= frameNxt;
      link.framePulse <= ctrl_r[CTRL_RUN_BIT] && pulseNxt;
      link.serialData <= ctrl_r[CTRL_RUN_BIT] && pattern_r[bitNxt[4:0]];
      if (active_r && bitNxt == 12'h000)
        framesSent_r <= framesSent_r + 16'h0001;
    end
  end

endmodule // tbmd_master
`default_nettype wire

// *** src/tbmd_pkg.sv ***
// shared constants, types and helpers of the transmit backplane demultiplexer
package tbmd_pkg;

  // ***********************************
  // widths
  // ***********************************
  localparam int NUM_CH     = 4;
  localparam int IDX_W      = 12;
  localparam int REG_ADDR_W = 12;
  localparam int REG_DATA_W = 8;

  // ***********************************
  // device register map
  // ***********************************
  localparam logic [11:0] IFACE_CTRL_OFS = 12'h120;
  localparam logic [11:0] FRAME_CFG_OFS  = 12'h109;
  localparam logic [7:0]  IFACE_CTRL_RST = 8'h00;
  localparam logic [7:0]  FRAME_CFG_RST  = 8'h00;
  localparam int SPEED_LSB  = 0;
  localparam int SPEED_MSB  = 1;
  localparam int MUX_EN_BIT = 7;
  localparam int SF_SEL_BIT = 5;

  typedef enum logic [1:0] {
    SPEED_BIT_12M = 2'b00,
    SPEED_RSVD    = 2'b01,
    SPEED_HMVIP   = 2'b10,
    SPEED_H100    = 2'b11
  } tbmd_speed_t;

  // ***********************************
  // frame geometry in high-speed bits
  // ***********************************
  localparam logic [11:0] FRAME_LEN_BIT  = 12'h608;
  localparam logic [11:0] FRAME_LEN_BYTE = 12'h800;
  localparam logic [11:0] FP_LEN_BIT     = 12'h008;
  localparam logic [11:0] OFF_HMVIP      = 12'h002;
  localparam logic [11:0] OFF_H100       = 12'h001;
  localparam int          SF_FRAMES_DEF  = 12;

  // ***********************************
  // timing
  // ***********************************
  localparam int CORE_KHZ     = 250000;
  localparam int HS_KHZ       = 16384;
  localparam int BASE_KHZ     = 1544;
  localparam logic [7:0] HS_HALF_DIV   = 8'(CORE_KHZ / (2 * HS_KHZ));
  localparam logic [7:0] BASE_HALF_DIV = 8'(CORE_KHZ / (2 * BASE_KHZ));
  // base half period reaches 40 link cycles at the fastest link divider
  localparam logic [5:0] BASE_TIMEOUT  = 6'h30;

  // ***********************************
  // controller register map
  // ***********************************
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] PATTERN_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS  = 4'h8;
  localparam logic [3:0] DIV_OFS     = 4'hc;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SPD_LSB = 1;
  localparam int CTRL_MUX_BIT = 3;
  localparam int CTRL_SF_BIT  = 4;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  function automatic logic [11:0] frameLen(tbmd_speed_t sp);
    frameLen = (sp == SPEED_BIT_12M) ? FRAME_LEN_BIT : FRAME_LEN_BYTE;
  endfunction

  // bits between the pulse's rising edge and the frame's first bit
  function automatic logic [11:0] alignOff(tbmd_speed_t sp);
    case (sp)
      SPEED_HMVIP: alignOff = OFF_HMVIP;
      SPEED_H100:  alignOff = OFF_H100;
      default:     alignOff = 12'h000;
    endcase
  endfunction

endpackage

// *** src/tbmd_link_if.sv ***
// backplane link between the bus master and the demultiplexing device
`timescale 1ns/1ps
`default_nettype none
interface tbmd_link_if;
  import tbmd_pkg::*;
  logic                  hsClk;
  logic                  baseClk;
  logic                  framePulse;
  logic                  serialData;
  logic                  regWrite;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [REG_DATA_W-1:0] regWrData;

  modport device (
    input hsClk, baseClk, framePulse, serialData, regWrite, regAddr, regWrData
  );
  modport master (
    output hsClk, baseClk, framePulse, serialData, regWrite, regAddr, regWrData
  );
endinterface
`default_nettype wire

// *** src/tbmd_device.sv ***
// device end: splits multiplexed backplane data onto four line channels
`timescale 1ns/1ps
`default_nettype none

module tbmd_device
  import tbmd_pkg::*;
#(
  parameter int SfFrames = SF_FRAMES_DEF
)(
  // backplane link
  tbmd_link_if.device        link,
  // reset, synchronous to the high-speed clock
  input  wire logic          reset,
  // line side
  output logic [NUM_CH-1:0]  lineData,
  output logic [NUM_CH-1:0]  lineValid,
  output logic               frameStart,
  output logic               superframeStart,
  // status
  output logic               modeError,
  output logic               baseClockOk
);

  // ***********************************
  // register port
  // ***********************************
  logic [7:0] ifaceCtrl_r;
  logic [7:0] frameCfg_r;

  always_ff @(posedge link.hsClk)
  begin
    if (reset)
    begin
      ifaceCtrl_r <= IFACE_CTRL_RST;
      frameCfg_r  <= FRAME_CFG_RST;
    end
    else if (link.regWrite)
    begin
      case (link.regAddr)
        IFACE_CTRL_OFS: ifaceCtrl_r <= link.regWrData;
        FRAME_CFG_OFS:  frameCfg_r  <= link.regWrData;
        default:        ;
      endcase
    end
  end

  tbmd_speed_t speed;
  logic        muxOn;
  logic        modeOk;
  logic        sfMode;
  logic        bitMode;
  logic [11:0] curLen;
  logic [11:0] curOff;

  always_comb
  begin
    speed   = tbmd_speed_t'(ifaceCtrl_r[SPEED_MSB:SPEED_LSB]);
    muxOn   = ifaceCtrl_r[MUX_EN_BIT];
    modeOk  = muxOn && (speed != SPEED_RSVD);
    sfMode  = frameCfg_r[SF_SEL_BIT];
    bitMode = (speed == SPEED_BIT_12M);
    curLen  = frameLen(speed);
    curOff  = alignOff(speed);
  end

  // ***********************************
  // pin sampling
  // ***********************************
  logic dataS_r;
  logic pulseS_r;
  logic pulseP_r;
  logic pulseRise;

  // both pins are launched on the falling edge, so one stage suffices
  always_ff @(posedge link.hsClk)
  begin
    if (reset)
    begin
      dataS_r  <= 1'b0;
      pulseS_r <= 1'b0;
      pulseP_r <= 1'b0;
    end
    else
    begin
      dataS_r  <= link.serialData;
      pulseS_r <= link.framePulse;
      pulseP_r <= pulseS_r;
    end
  end

  assign pulseRise = pulseS_r && !pulseP_r;

  // ***********************************
  // frame position
  // ***********************************
  logic [IDX_W-1:0] frameBit_r;
  logic [IDX_W-1:0] bitIdx;
  logic [1:0]       chan;
  logic             atStart;

  // the rising sample sits curOff bits before the frame's first bit
  always_comb
  begin
    if (pulseRise)
      bitIdx = (curOff == 12'h000) ? 12'h000 : curLen - curOff;
    else if (frameBit_r >= curLen - 12'h001)
      bitIdx = 12'h000;
    else
      bitIdx = frameBit_r + 12'h001;
    atStart = (bitIdx == 12'h000);
    // frame lengths are multiples of 8, byte frames of 32, so the low bits stay aligned
    chan    = bitMode ? bitIdx[1:0] : bitIdx[4:3];
  end

  always_ff @(posedge link.hsClk)
  begin
    if (reset)
      frameBit_r <= '0;
    else
      frameBit_r <= bitIdx;
  end

  // ***********************************
  // superframe tracking
  // ***********************************
  logic [7:0] frameCnt_r;
  logic [7:0] frameCnt_nxt;
  logic       sfAlign_r;

  always_comb
  begin
    frameCnt_nxt = frameCnt_r;
    if (atStart)
    begin
      if (sfMode && (sfAlign_r || pulseRise))
        frameCnt_nxt = 8'h00;
      else if (frameCnt_r >= 8'(SfFrames - 1))
        frameCnt_nxt = 8'h00;
      else
        frameCnt_nxt = frameCnt_r + 8'h01;
    end
  end

  always_ff @(posedge link.hsClk)
  begin
    if (reset)
    begin
      frameCnt_r <= 8'h00;
      sfAlign_r  <= 1'b0;
    end
    else
    begin
      frameCnt_r <= frameCnt_nxt;
      // a rise ahead of the boundary waits here for the frame start
      if (pulseRise && !atStart)
        sfAlign_r <= 1'b1;
      else if (atStart)
        sfAlign_r <= 1'b0;
    end
  end

  // ***********************************
  // line outputs
  // ***********************************
  always_ff @(posedge link.hsClk)
  begin
    if (reset)
    begin
      lineData        <= '0;
      lineValid       <= '0;
      frameStart      <= 1'b0;
      superframeStart <= 1'b0;
      modeError       <= 1'b0;
    end
    else
    begin
      lineValid       <= '0;
      frameStart      <= modeOk && atStart;
      superframeStart <= modeOk && atStart && sfMode && (frameCnt_nxt == 8'h00);
      modeError       <= muxOn && (speed == SPEED_RSVD);
      if (modeOk)
      begin
        lineData[chan]  <= dataS_r;
        lineValid[chan] <= 1'b1;
      end
    end
  end

  // ***********************************
  // base clock monitor
  // ***********************************
  logic       baseMeta_r;
  logic       baseSync_r;
  logic       baseLast_r;
  logic [5:0] baseIdle_r;

  // base clock is slower than the link clock, so a timeout shows it stopped
  always_ff @(posedge link.hsClk)
  begin
    if (reset)
    begin
      baseMeta_r  <= 1'b0;
      baseSync_r  <= 1'b0;
      baseLast_r  <= 1'b0;
      baseIdle_r  <= 6'h00;
      baseClockOk <= 1'b0;
    end
    else
    begin
      baseMeta_r <= link.baseClk;
      baseSync_r <= baseMeta_r;
      baseLast_r <= baseSync_r;
      if (baseSync_r != baseLast_r)
      begin
        baseIdle_r  <= 6'h00;
        baseClockOk <= 1'b1;
      end
      else if (baseIdle_r >= BASE_TIMEOUT)
        baseClockOk <= 1'b0;
      else
        baseIdle_r <= baseIdle_r + 6'h01;
    end
  end

endmodule // tbmd_device
`default_nettype wire

// *** src/unused_placeholder_note.sv ***
// intentionally empty unit kept out of compile
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verif/tbmd_chk.sv ***
// assertion checker on the backplane link between master and device
`timescale 1ns/1ps
`default_nettype none
module tbmd_chk
  import tbmd_pkg::*;
(
  // link
  input wire logic                  hsClk,
  input wire logic                  reset,
  input wire logic                  framePulse,
  input wire logic                  regWrite,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWrData
);
  // ***********************************
  // mode tracking
  // ***********************************
  logic [1:0]  spd_r;
  logic        mux_r;
  logic        sf_r;
  logic        armed_r;
  logic        pulse_r;
  logic [11:0] gap_r;
  logic        rise;
  logic        chk;

  assign rise = framePulse && !pulse_r;
  // first pulse after a config write may be cut short, so it only arms
  assign chk = rise && armed_r && mux_r;

  always_ff @(posedge hsClk)
    if (reset)
      {spd_r, mux_r} <= 3'h0;
    else if (regWrite && regAddr == IFACE_CTRL_OFS)
      {spd_r, mux_r} <= {regWrData[SPEED_MSB:SPEED_LSB], regWrData[MUX_EN_BIT]};

  always_ff @(posedge hsClk)
    if (reset)
      sf_r <= 1'b0;
    else if (regWrite && regAddr == FRAME_CFG_OFS)
      sf_r <= regWrData[SF_SEL_BIT];

  always_ff @(posedge hsClk)
    if (reset || regWrite)
      armed_r <= 1'b0;
    else if (rise)
      armed_r <= 1'b1;

  always_ff @(posedge hsClk)
    pulse_r <= reset ? 1'b0 : framePulse;

  always_ff @(posedge hsClk)
    if (reset || rise)
      gap_r <= 12'h001;
    else if (gap_r != 12'hfff)
      gap_r <= gap_r + 12'h001;

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge hsClk); endclocking
  default disable iff (reset);

  cfg_order_a: assert property (
    regWrite && regAddr == IFACE_CTRL_OFS |=> regWrite && regAddr == FRAME_CFG_OFS)
    else $error("frame config write did not follow control write");
  cfg_end_a: assert property (
    regWrite && regAddr == FRAME_CFG_OFS |=> !regWrite)
    else $error("register write longer than one period");
  cfg_addr_a: assert property (
    $rose(regWrite) |-> regAddr == IFACE_CTRL_OFS)
    else $error("config sequence began at wrong register");
  bit_width_a: assert property (
    disable iff (reset || regWrite)
    chk && spd_r == SPEED_BIT_12M |-> framePulse[*8] ##1 !framePulse)
    else $error("bit mode frame pulse width wrong");
  hmvip_width_a: assert property (
    disable iff (reset || regWrite)
    chk && spd_r == SPEED_HMVIP |-> framePulse[*4] ##1 !framePulse)
    else $error("hmvip frame pulse width wrong");
  h100_width_a: assert property (
    disable iff (reset || regWrite)
    chk && spd_r == SPEED_H100 |-> framePulse[*2] ##1 !framePulse)
    else $error("h100 frame pulse width wrong");
  bit_gap_a: assert property (
    chk && !sf_r && spd_r == SPEED_BIT_12M |-> gap_r == FRAME_LEN_BIT)
    else $error("bit mode frame length wrong");
  byte_gap_a: assert property (
    chk && !sf_r && spd_r[1] |-> gap_r == FRAME_LEN_BYTE)
    else $error("byte mode frame length wrong");
endmodule // tbmd_chk
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench joining the backplane master and device
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tbmd_pkg::*;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              devReset = 1'b1;
  logic [3:0]        s_axi_awaddr = 4'h0;
  logic [3:0]        s_axi_araddr = 4'h0;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic [31:0]       s_axi_rdata, rdata;
  logic [NUM_CH-1:0] lineData, lineValid;
  logic [NUM_CH-1:0] expBit = 4'h0;
  logic              frameStart, superframeStart, modeError, baseClockOk;
  logic              mon = 1'b0;
  int                n_fail = 0;
  int                checks_done = 0;
  int                cycles = 0;
  int                nBad, nFrame, nSuper;
  int                nValid [NUM_CH];

  initial forever #2 core_clk = ~core_clk;

  tbmd_link_if link ();
  tbmd_master #(.SfFrames(2)) i_tbmd_master (
    .core_clk(core_clk), .reset(reset), .link(link.master),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  tbmd_device #(.SfFrames(2)) i_tbmd_device (
    .link(link.device), .reset(devReset), .lineData(lineData), .lineValid(lineValid),
    .frameStart(frameStart), .superframeStart(superframeStart), .modeError(modeError),
    .baseClockOk(baseClockOk));
  tbmd_chk i_tbmd_chk (
    .hsClk(link.hsClk), .reset(reset), .framePulse(link.framePulse),
    .regWrite(link.regWrite), .regAddr(link.regAddr), .regWrData(link.regWrData));

  // ***********************************
  // common tasks
  // ***********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // outputs move on the rising edge, so they are sampled on the falling one
  always @(negedge link.hsClk)
    if (mon)
    begin
      for (int c = 0; c < NUM_CH; c++)
        if (lineValid[c] === 1'b1)
        begin
          nValid[c]++;
          nBad += int'(lineData[c] !== expBit[c]);
        end
      nFrame += int'(frameStart === 1'b1);
      nSuper += int'(superframeStart === 1'b1);
    end

  task automatic watch(input int n);
    nBad = 0;
    nFrame = 0;
    nSuper = 0;
    foreach (nValid[c])
      nValid[c] = 0;
    mon = 1'b1;
    repeat (n) @(posedge core_clk);
    mon = 1'b0;
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task automatic runMode(input logic [1:0] spd, input logic sf, input logic [31:0] pat,
                         input logic [3:0] e, input int n);
    axiWrite(CTRL_OFS, 32'h0, resp);
    repeat (300) @(posedge core_clk);
    axiWrite(PATTERN_OFS, pat, resp);
    axiWrite(CTRL_OFS, {27'h0, sf, 1'b1, spd, 1'b1}, resp);
    check(32'(resp), 32'(AXI_OKAY), "ctrl write");
    expBit = e;
    // byte modes lock on the first full pulse: one frame in, two with superframes
    if (spd != SPEED_BIT_12M)
      repeat ((sf ? 4 : 2) * int'(FRAME_LEN_BYTE) + 64) @(posedge core_clk);
    watch(n);
    check(32'(nBad), 32'h0, "line bits on wrong channel");
    foreach (nValid[c])
      check({31'h0, nValid[c] > 0 && nValid[c] - nValid[0] <= 8 && nValid[0] - nValid[c] <= 8},
            32'h1, "channel share");
    check({31'h0, nFrame >= 2}, 32'h1, "frame starts");
    check({31'h0, sf ? (nSuper >= 1 && nSuper <= nFrame) : nSuper == 0}, 32'h1,
          "superframe starts");
    axiRead(STATUS_OFS, rdata, resp);
    check({31'h0, rdata[0] && rdata[31:16] != 16'h0}, 32'h1, "status running");
    check(32'(baseClockOk), 32'h1, "base clock seen");
  endtask

  task automatic refused(input logic [1:0] spd, input logic mux, input logic err);
    axiWrite(CTRL_OFS, {28'h0, mux, spd, 1'b1}, resp);
    repeat (50) @(posedge core_clk);
    watch(3000);
    check(32'(nFrame + nValid.sum()), 32'h0, "output while refused");
    check(32'(modeError), 32'(err), "mode error flag");
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    repeat (40) @(posedge core_clk);
    devReset <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'({lineValid, frameStart, superframeStart, modeError}), 32'h0, "outputs at reset");
    axiRead(CTRL_OFS, rdata, resp);
    check(rdata, 32'h0, "ctrl at reset");
    axiWrite(4'h2, 32'h1, resp);
    check(32'(resp), 32'(AXI_SLVERR), "unmapped write");
    axiRead(4'h2, rdata, resp);
    check({resp, rdata[29:0]}, {AXI_SLVERR, 30'h0}, "unmapped read");
    axiWrite(DIV_OFS, 32'h1, resp);
    axiRead(DIV_OFS, rdata, resp);
    check(rdata, 32'h1, "divider readback");
    runMode(SPEED_BIT_12M, 1'b0, 32'hcccccccc, 4'b1100, 13000);
    runMode(SPEED_HMVIP, 1'b0, 32'hff00ff00, 4'b1010, 13000);
    runMode(SPEED_H100, 1'b0, 32'hff00ff00, 4'b1010, 13000);
    runMode(SPEED_H100, 1'b1, 32'h00ff00ff, 4'b0101, 20000);
    refused(SPEED_RSVD, 1'b1, 1'b1);
    refused(SPEED_HMVIP, 1'b0, 1'b0);
    finish_test();
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      finish_test();
    end
  end
endmodule // tb_top
`default_nettype wire
